// ---- design/prom_prog_pkg.sv ----
package prom_prog_pkg;
	// ------------------------------------------------------------
	// Array and timing
	// ------------------------------------------------------------
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] LAST_ADDR = 10'h3ff;
	localparam int CLOCK_MHZ = 40;
	localparam int INIT_PULSE_US = 100;
	localparam int BRUTE_PULSE_US = 10000;
	localparam int OVER_FACTOR = 24;
	localparam int MAX_INIT_PULSES = 4;
	localparam int SETUP_US = 1;
	localparam int VERIFY_US = 2;
	localparam int SUPPLY_US = 1;
	localparam int INIT_PULSE_CYC = INIT_PULSE_US * CLOCK_MHZ;
	localparam int BRUTE_PULSE_CYC = BRUTE_PULSE_US * CLOCK_MHZ;
	localparam int SETUP_CYC = SETUP_US * CLOCK_MHZ;
	localparam int VERIFY_CYC = VERIFY_US * CLOCK_MHZ;
	localparam int SUPPLY_CYC = SUPPLY_US * CLOCK_MHZ;
	localparam int CNT_W = 24;
	localparam int ITER_W = 3;

	// ------------------------------------------------------------
	// Commands and pin bundle
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		CMD_PROGRAM,
		CMD_BLANK_ONES,
		CMD_BLANK_ZEROS
	} cmd_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic data_oe;
		logic program_strobe_n;
		logic verify_strobe_n;
		logic vpp_high;
		logic blank_mode_vpp;
		logic chip_select_n;
		logic programming_core_supply;
	} pins_t;
endpackage

// ---- design/prom_pulse_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module prom_pulse_timer (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_start,
	input wire logic [prom_prog_pkg::CNT_W-1:0] i_cycles,
	output logic o_done
);
	import prom_prog_pkg::*;
	logic [CNT_W-1:0] count_q;
	logic busy_q;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			count_q <= '0;
			busy_q <= 1'b0;
		end else if (i_start) begin
			count_q <= i_cycles;
			busy_q <= 1'b1;
		end else if (busy_q) begin
			if (count_q <= 24'h000001) begin
				busy_q <= 1'b0;
			end
			count_q <= count_q - 24'h000001;
		end
	end

	assign o_done = busy_q && (count_q <= 24'h000001);
endmodule
`default_nettype wire

// ---- design/prom_program_sequencer.sv ----
// Function
// - Initial program pulse lasts 0.1 ms
// - Overprogram pulse is 24 x 0.1ms x count
// - Count initial pulses, clear per address
// - At most four initial pulses per byte
// - Read back whole array and compare
// - Blank check steps addresses 0 to 1023
// - Blank ones/zeros mismatch means non-blank
// - Program every bit, ones and zeros
// - Write every location, unused ones too
// - Core supply before high voltage, reverse off
// - High voltage, strobes idle: inhibit
// - Repeat program-verify up to four times
// - Brute force: one 10 ms pulse, reject
`timescale 1ns/1ps
`default_nettype none
module prom_program_sequencer (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_start,
	input wire prom_prog_pkg::cmd_t i_cmd,
	input wire logic i_brute,
	input wire logic [prom_prog_pkg::DATA_W-1:0] i_src_data,
	output logic [prom_prog_pkg::ADDR_W-1:0] o_src_addr,
	input wire logic [prom_prog_pkg::DATA_W-1:0] i_dev_data,
	output prom_prog_pkg::pins_t o_pins,
	output logic o_busy,
	output logic o_done,
	output logic o_fail,
	output logic [prom_prog_pkg::ADDR_W-1:0] o_fail_addr
);
	import prom_prog_pkg::*;

	typedef enum {
		ST_IDLE, ST_CORE_UP, ST_VPP_UP, ST_SETUP, ST_PULSE, ST_VFY_GAP, ST_VERIFY,
		ST_OVER, ST_NEXT, ST_VPP_DOWN, ST_CORE_DOWN, ST_READ, ST_READ_CMP, ST_BLANK,
		ST_BLANK_CMP, ST_END
	} state_t;

	state_t state_q;
	cmd_t cmd_q;
	logic brute_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] data_q;
	logic [ITER_W-1:0] iter_q;
	logic fail_q;
	logic done_q;
	logic [ADDR_W-1:0] fail_addr_q;
	logic [DATA_W-1:0] s1_q, s2_q, s3_q, dev_q;
	logic t_done;
	logic t_start_q;
	logic [CNT_W-1:0] t_cycles_q;
	logic waiting_q;

	// ------------------------------------------------------------
	// Device data input: three stages, accepted when last two agree
	// ------------------------------------------------------------
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			dev_q <= '0;
		end else begin
			s1_q <= i_dev_data;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				dev_q <= s3_q;
			end
		end
	end

	// ------------------------------------------------------------
	// Timer
	// ------------------------------------------------------------
	function automatic logic [CNT_W-1:0] over_cycles(input logic [ITER_W-1:0] n);
		over_cycles = CNT_W'(OVER_FACTOR * INIT_PULSE_CYC) * CNT_W'(n);
	endfunction

	prom_pulse_timer timer (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_start(t_start_q),
		.i_cycles(t_cycles_q),
		.o_done(t_done)
	);

	// Timer is armed one cycle after each entry to a state other than ST_IDLE and ST_END

	function automatic logic [CNT_W-1:0] wait_for(input state_t s, input logic brute,
			input logic [ITER_W-1:0] n);
		case (s)
			ST_PULSE: wait_for = brute ? CNT_W'(BRUTE_PULSE_CYC) : CNT_W'(INIT_PULSE_CYC);
			ST_OVER: wait_for = over_cycles(n);
			ST_VERIFY, ST_READ: wait_for = CNT_W'(VERIFY_CYC);
			// Compares need no dwell; a blank read only waits one settle time
			ST_READ_CMP, ST_BLANK_CMP: wait_for = '0;
			ST_CORE_UP, ST_VPP_UP, ST_VPP_DOWN, ST_CORE_DOWN: wait_for = CNT_W'(SUPPLY_CYC);
			default: wait_for = CNT_W'(SETUP_CYC);
		endcase
	endfunction

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state_q <= ST_IDLE;
			cmd_q <= CMD_PROGRAM;
			brute_q <= 1'b0;
			addr_q <= '0;
			data_q <= '0;
			iter_q <= '0;
			fail_q <= 1'b0;
			done_q <= 1'b0;
			fail_addr_q <= '0;
			t_start_q <= 1'b0;
			t_cycles_q <= '0;
			waiting_q <= 1'b0;
		end else begin
			t_start_q <= 1'b0;
			if (state_q != ST_IDLE && state_q != ST_END && !waiting_q) begin
				t_start_q <= 1'b1;
				t_cycles_q <= wait_for(state_q, brute_q, iter_q);
				waiting_q <= 1'b1;
			end
			case (state_q)
				ST_IDLE: begin
					if (i_start) begin
						cmd_q <= i_cmd;
						brute_q <= i_brute;
						addr_q <= '0;
						iter_q <= '0;
						fail_q <= 1'b0;
						done_q <= 1'b0;
						waiting_q <= 1'b0;
						state_q <= (i_cmd == CMD_PROGRAM) ? ST_CORE_UP : ST_BLANK;
					end
				end
				ST_END: begin
					state_q <= ST_IDLE;
				end
				default: begin
					if (t_done) begin
						waiting_q <= 1'b0;
						case (state_q)
							ST_CORE_UP: state_q <= ST_VPP_UP;
							ST_VPP_UP: state_q <= ST_SETUP;
							ST_SETUP: begin
								data_q <= i_src_data;
								state_q <= ST_PULSE;
							end
							ST_PULSE: begin
								iter_q <= iter_q + 3'h1;
								state_q <= ST_VFY_GAP;
							end
							ST_VFY_GAP: state_q <= ST_VERIFY;
							ST_VERIFY: begin
								if (dev_q == data_q) begin
									state_q <= brute_q ? ST_NEXT : ST_OVER;
								end else if (!brute_q &&
										iter_q < ITER_W'(MAX_INIT_PULSES)) begin
									state_q <= ST_PULSE;
								end else begin
									fail_q <= 1'b1;
									fail_addr_q <= addr_q;
									state_q <= ST_VPP_DOWN;
								end
							end
							ST_OVER: state_q <= ST_NEXT;
							ST_NEXT: begin
								iter_q <= '0;
								if (addr_q == LAST_ADDR) begin
									state_q <= ST_VPP_DOWN;
								end else begin
									addr_q <= addr_q + 10'h001;
									state_q <= ST_SETUP;
								end
							end
							ST_VPP_DOWN: state_q <= ST_CORE_DOWN;
							ST_CORE_DOWN: begin
								addr_q <= '0;
								state_q <= fail_q ? ST_END : ST_READ;
							end
							ST_READ: state_q <= ST_READ_CMP;
							ST_READ_CMP: begin
								if (dev_q != i_src_data) begin
									fail_q <= 1'b1;
									fail_addr_q <= addr_q;
									state_q <= ST_END;
								end else if (addr_q == LAST_ADDR) begin
									done_q <= 1'b1;
									state_q <= ST_END;
								end else begin
									addr_q <= addr_q + 10'h001;
									state_q <= ST_READ;
								end
							end
							ST_BLANK: state_q <= ST_BLANK_CMP;
							ST_BLANK_CMP: begin
								// Virgin cells only read defined in blank modes
								if (dev_q != ((cmd_q == CMD_BLANK_ONES) ? 8'hff : 8'h00)) begin
									fail_q <= 1'b1;
									fail_addr_q <= addr_q;
									state_q <= ST_END;
								end else if (addr_q == LAST_ADDR) begin
									done_q <= 1'b1;
									state_q <= ST_END;
								end else begin
									addr_q <= addr_q + 10'h001;
									state_q <= ST_BLANK;
								end
							end
							default: state_q <= ST_IDLE;
						endcase
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Pins
	// ------------------------------------------------------------
	pins_t pins_q;
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			pins_q <= '{addr: '0, data: '0, data_oe: 1'b0, program_strobe_n: 1'b1,
				verify_strobe_n: 1'b1, vpp_high: 1'b0, blank_mode_vpp: 1'b0,
				chip_select_n: 1'b1, programming_core_supply: 1'b0};
		end else begin
			pins_q.addr <= addr_q;
			pins_q.data <= data_q;
			pins_q.data_oe <= state_q inside {ST_SETUP, ST_PULSE, ST_OVER};
			// Release on the timer's last cycle so the low time equals the count
			pins_q.program_strobe_n <= !(waiting_q && !t_done &&
				state_q inside {ST_PULSE, ST_OVER});
			pins_q.verify_strobe_n <= !(state_q == ST_VERIFY);
			pins_q.programming_core_supply <= !(state_q inside
				{ST_IDLE, ST_END, ST_CORE_DOWN, ST_READ, ST_READ_CMP, ST_BLANK,
				ST_BLANK_CMP});
			pins_q.vpp_high <= state_q inside
				{ST_SETUP, ST_PULSE, ST_VFY_GAP, ST_VERIFY, ST_OVER, ST_NEXT};
			pins_q.blank_mode_vpp <= state_q inside {ST_BLANK, ST_BLANK_CMP};
			pins_q.chip_select_n <= (state_q == ST_IDLE || state_q == ST_END);
			if (state_q inside {ST_BLANK, ST_BLANK_CMP}) begin
				pins_q.verify_strobe_n <= (cmd_q == CMD_BLANK_ZEROS);
			end
		end
	end

	assign o_pins = pins_q;
	assign o_src_addr = addr_q;
	assign o_busy = (state_q != ST_IDLE);
	assign o_done = done_q;
	assign o_fail = fail_q;
	assign o_fail_addr = fail_addr_q;
endmodule
`default_nettype wire

// ---- tb/prom_seq_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module prom_seq_monitor
	import prom_prog_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire pins_t o_pins,
	input wire logic o_busy,
	input wire logic o_done,
	input wire logic o_fail
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// ------
	// Pulse length and pulses per byte
	// ------
	logic [CNT_W-1:0] low_q;
	logic [3:0] np_q;
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst)
			low_q <= '0;
		else
			low_q <= o_pins.program_strobe_n ? '0 : low_q + 1'b1;
	end
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst)
			np_q <= '0;
		else
			np_q <= (!o_busy || $changed(o_pins.addr)) ? '0 :
				np_q + {3'h0, $fell(o_pins.program_strobe_n)};
	end
	sequence s_hv_up;
		$rose(o_pins.vpp_high);
	endsequence
	chk_pulse_len: assert property ($rose(o_pins.program_strobe_n) |->
		low_q % INIT_PULSE_CYC == 0) else $error("pulse not a whole step");
	chk_pulse_cap: assert property (np_q <= 4'h5)
		else $error("too many pulses on one byte");
	chk_hv_after: assert property (s_hv_up |-> $past(o_pins.programming_core_supply))
		else $error("high voltage before core supply");
	chk_supply_drop: assert property ($fell(o_pins.programming_core_supply) |->
		!$past(o_pins.vpp_high)) else $error("core supply dropped first");
	chk_pgm_hv: assert property (!o_pins.program_strobe_n |-> o_pins.vpp_high)
		else $error("pulse without high voltage");
	chk_verify_bus: assert property (!o_pins.verify_strobe_n |->
		o_pins.program_strobe_n && !o_pins.data_oe) else $error("bus clash in verify");
	chk_hold_stable: assert property (!o_pins.program_strobe_n |=>
		$stable(o_pins.addr) && $stable(o_pins.data)) else $error("address or data moved");
	chk_idle_safe: assert property (!o_busy |->
		o_pins.program_strobe_n && !o_pins.vpp_high) else $error("idle pins not safe");
	chk_end_state: assert property ($rose(o_done) |-> !o_fail ##1 !o_busy)
		else $error("bad end flags");
	chk_fail_stops: assert property ($rose(o_fail) |-> ##[1:200] !o_busy)
		else $error("no stop after failure");
	chk_fail_quiet: assert property (o_fail |-> o_pins.program_strobe_n)
		else $error("pulse after failure");
endmodule
bind prom_program_sequencer prom_seq_monitor u_mon (.i_clock(i_clock), .i_rst(i_rst),
	.o_pins(o_pins), .o_busy(o_busy), .o_done(o_done), .o_fail(o_fail));
`default_nettype wire

// ---- tb/prom_device_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module prom_device_model
	import prom_prog_pkg::*;
(
	input wire logic i_clock,
	input wire pins_t i_pins,
	output logic [DATA_W-1:0] o_data
);
	// ------
	// A cell that never takes its charge
	// ------
	logic [DATA_W-1:0] prog_q = 8'h00;
	logic [DATA_W-1:0] last_q = 8'h00;
	logic touched_q = 1'b0;
	always @(negedge i_pins.program_strobe_n) begin
		if (i_pins.vpp_high === 1'b1) begin
			prog_q = i_pins.data;
			touched_q = 1'b1;
		end
	end
	// A pulsed cell is no longer virgin and shows its charge in both blank modes
	always @* begin
		if (i_pins.blank_mode_vpp && !i_pins.vpp_high && touched_q)
			o_data = prog_q;
		else if (i_pins.blank_mode_vpp && !i_pins.vpp_high)
			o_data = i_pins.verify_strobe_n ? 8'h00 : 8'hff;
		else if (i_pins.vpp_high && !i_pins.verify_strobe_n)
			o_data = ~prog_q;
		else
			o_data = ~last_q;
	end
	// Released bus toggles so a stale value never looks valid
	always @(posedge i_clock)
		last_q <= o_data;
endmodule
`default_nettype wire

// ---- tb/prom_program_sequencer_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module prom_program_sequencer_tb_top;
	import prom_prog_pkg::*;
	logic i_clock, i_rst, i_start, busy, done, fail, seen, brute;
	cmd_t i_cmd;
	logic [DATA_W-1:0] src, dev;
	logic [ADDR_W-1:0] sa, fa, top;
	pins_t pins;
	int failures, checks, pulses;
	prom_program_sequencer DUT (.i_clock(i_clock), .i_rst(i_rst), .i_start(i_start),
		.i_cmd(i_cmd), .i_brute(brute), .i_src_data(src), .o_src_addr(sa), .i_dev_data(dev),
		.o_pins(pins), .o_busy(busy), .o_done(done), .o_fail(fail), .o_fail_addr(fa));
	prom_device_model model (.i_clock(i_clock), .i_pins(pins), .o_data(dev));
	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		src <= 8'h5a ^ sa[7:0];
		if (pins.blank_mode_vpp === 1'b1) begin
			seen <= 1'b1;
			top <= (pins.addr > top) ? pins.addr : top;
		end
	end
	always @(negedge pins.program_strobe_n)
		pulses++;
	task automatic check(input string what, input logic [ADDR_W-1:0] got, exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop();
		if (failures == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic start_cmd(input cmd_t c, input logic b = 1'b0);
		@(posedge i_clock);
		i_start <= 1'b1;
		i_cmd <= c;
		brute <= b;
		@(posedge i_clock);
		i_start <= 1'b0;
		#1;
		check("busy", busy, 1'b1);
		@(posedge i_clock);
	endtask
	task automatic wait_idle(input int limit);
		int n;
		for (n = 0; n < limit && busy !== 1'b0; n++) begin
			@(posedge i_clock);
			#1;
		end
		check("finished", n < limit, 1'b1);
	endtask
	task automatic blank_ones_test();
		top = '0;
		start_cmd(CMD_BLANK_ONES);
		wait_idle(60000);
		check("blank done", done, 1'b1);
		check("blank fail", fail, 1'b0);
		check("blank top", top, LAST_ADDR);
	endtask
	task automatic program_fail_test();
		pulses = 0;
		seen = 1'b0;
		start_cmd(CMD_PROGRAM);
		repeat (10) @(posedge i_clock);
		start_cmd(CMD_BLANK_ONES);
		wait_idle(60000);
		check("fail", fail, 1'b1);
		check("done", done, 1'b0);
		check("fail addr", fa, '0);
		check("pulses", pulses[ADDR_W-1:0], 10'h4);
		check("refused", seen, 1'b0);
	endtask
	task automatic blank_zeros_test();
		start_cmd(CMD_BLANK_ZEROS);
		#1;
		check("zeros mode", pins.verify_strobe_n, 1'b1);
		wait_idle(1000);
		check("zeros fail", fail, 1'b1);
		check("zeros done", done, 1'b0);
		check("zeros addr", fa, '0);
	endtask
	task automatic brute_reset_test();
		int n;
		start_cmd(CMD_PROGRAM, 1'b1);
		for (n = 0; n < 300 && pins.program_strobe_n !== 1'b0; n++) begin
			@(posedge i_clock);
			#1;
		end
		check("brute pulse", n < 300, 1'b1);
		repeat (4100) @(posedge i_clock);
		#1;
		check("brute length", pins.program_strobe_n, 1'b0);
		@(posedge i_clock);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clock);
		#1;
		check("reset high voltage", pins.vpp_high, 1'b0);
		check("reset supply", pins.programming_core_supply, 1'b0);
		check("reset strobe", pins.program_strobe_n, 1'b1);
		check("reset busy", busy, 1'b0);
		@(posedge i_clock);
		i_rst <= 1'b0;
		start_cmd(CMD_BLANK_ZEROS);
		wait_idle(1000);
		check("after reset fail", fail, 1'b1);
		check("after reset addr", fa, '0);
	endtask
	initial begin
		failures = 0;
		checks = 0;
		pulses = 0;
		seen = 1'b0;
		brute = 1'b0;
		top = '0;
		src = 8'h00;
		i_rst = 1'b1;
		i_start = 1'b0;
		i_cmd = CMD_PROGRAM;
		repeat (12) @(posedge i_clock);
		#1;
		check("supply in reset", pins.programming_core_supply, 1'b0);
		@(posedge i_clock);
		i_rst <= 1'b0;
		@(posedge i_clock);
		blank_ones_test();
		program_fail_test();
		blank_zeros_test();
		brute_reset_test();
		report_and_stop();
	end
	initial begin
		repeat (90000) @(posedge i_clock);
		failures++;
		report_and_stop();
	end
endmodule
`default_nettype wire
